/* hdl/hsrp_host_port.sv */
// Purpose: Host serial register port, SPI or single-wire UART
// Assumes: Status inputs come from logic on clk; pins are asynchronous
// Notes: UART read replies are not produced; read requests are received and dropped without a checksum or node check
`timescale 1ns/100ps
module hsrp_host_port
  import hsrp_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic uartModeSelect,
  input wire logic lowPowerMode,
  input wire logic spiClk,
  input wire logic spiCsN,
  input wire logic spiDataIn,
  output logic spiDataOut,
  output logic spiDataOutEn,
  input wire logic singleWireDataPinIn,
  output logic singleWireDataPinOut,
  output logic singleWireDataPinOutEn,
  input wire logic stopLeft,
  input wire logic stopRight,
  input wire logic loadStallHalt,
  input wire logic virtualStopLeft,
  input wire logic virtualStopRight,
  input wire logic positionReached,
  input wire logic velocityReached,
  input wire logic driverFaultEvent,
  output logic [hsrp_pkg::ADDR_BITS-1:0] regAddr,
  output logic [hsrp_pkg::DATA_BITS-1:0] regWriteData,
  output logic regWriteStrobe,
  output logic regReadStrobe,
  input wire logic [hsrp_pkg::DATA_BITS-1:0] regReadData,
  output logic clockSourceInternal
);
  import hsrp_pkg::*;

  // Synchronised pins
  logic [5:0] pinSync;
  logic lineLevel;
  logic csSync;
  logic sckSync;
  logic sdiSync;
  logic uartMode;
  logic lowPower;

  hsrp_sync #(.WIDTH(6)) pinSyncInst (
    .clk(clk),
    .d({singleWireDataPinIn, spiCsN, spiClk, spiDataIn, uartModeSelect, lowPowerMode}),
    .q(pinSync)
  );

  assign lineLevel = pinSync[5];
  assign csSync = pinSync[4];
  assign sckSync = pinSync[3];
  assign sdiSync = pinSync[2];
  assign uartMode = pinSync[1];
  assign lowPower = pinSync[0];

  // SPI link
  logic [FRAME_BITS-1:0] txWord;
  logic [FRAME_BITS-1:0] rxWord;

  hsrp_spi_link spiLinkInst (
    .spiClk(spiClk),
    .spiCsN(spiCsN),
    .spiDataIn(spiDataIn),
    .txWord(txWord),
    .rxWord(rxWord),
    .spiDataOut(spiDataOut),
    .spiDataOutEn(spiDataOutEn)
  );

  function automatic logic isLocal(input logic [ADDR_BITS-1:0] addr);
    isLocal = (addr == ADDR_GLOBAL_STATE) || (addr == ADDR_NODE_SETUP);
  endfunction

  function automatic logic [7:0] crc8Byte(input logic [7:0] crcIn, input logic [7:0] dataIn);
    logic [7:0] c;
    c = crcIn;
    for (int i = 0; i < 8; i++) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ dataIn[i]) ? CRC_POLY : 8'h00);
    end
    crc8Byte = c;
  endfunction

  // Register state
  logic resetFlag;
  logic driverError;
  logic [7:0] nodeAddressField;
  logic [2:0] strapValue;
  logic strapPending;
  logic csPrev;
  logic linePrev;
  logic next_resetFlag;
  logic next_driverError;
  logic [7:0] next_nodeAddressField;
  logic [2:0] next_strapValue;
  logic next_strapPending;
  logic [ADDR_BITS-1:0] next_regAddr;
  logic [DATA_BITS-1:0] next_regWriteData;
  logic next_regWriteStrobe;
  logic next_regReadStrobe;

  logic csRise;
  logic lineFall;
  logic [7:0] activeNode;
  logic [7:0] statusByte;
  logic [DATA_BITS-1:0] readValue;

  assign csRise = csSync && !csPrev;
  assign lineFall = linePrev && !lineLevel;
  assign activeNode = nodeAddressField + {5'h00, strapValue};

  always_comb begin
    statusByte = 8'h00;
    statusByte[ST_STOP] = stopLeft | stopRight | loadStallHalt
                        | virtualStopLeft | virtualStopRight;
    statusByte[ST_POSITION] = positionReached;
    statusByte[ST_VELOCITY] = velocityReached;
    statusByte[ST_DRIVER_ERROR] = driverError;
    statusByte[ST_RESET_FLAG] = resetFlag;
  end

  // Read data, right aligned
  always_comb begin
    readValue = regReadData;
    if (regAddr == ADDR_GLOBAL_STATE) begin
      readValue = '0;
      readValue[GS_DRIVER_ERROR] = driverError;
      readValue[GS_RESET_FLAG] = resetFlag;
    end else if (regAddr == ADDR_NODE_SETUP) begin
      readValue = {24'h000000, nodeAddressField};
    end
  end

  // SPI command handling
  hsrp_spi_state_t spiState;
  hsrp_spi_state_t next_spiState;
  logic [7:0] statusLatch;
  logic [7:0] next_statusLatch;
  logic [FRAME_BITS-1:0] next_txWord;
  logic spiWr;
  logic spiRd;

  always_comb begin
    next_spiState = spiState;
    next_statusLatch = statusLatch;
    next_txWord = txWord;
    spiWr = 1'b0;
    spiRd = 1'b0;
    case (spiState)
      S_IDLE: begin
        if (csRise && !uartMode) begin
          next_statusLatch = statusByte;
          if (rxWord[WRITE_SELECT_BIT]) begin
            spiWr = 1'b1;
            next_txWord = {statusByte, rxWord[DATA_BITS-1:0]};
          end else begin
            spiRd = 1'b1;
            next_spiState = S_READ_WAIT;
          end
        end
      end
      S_READ_WAIT: begin
        next_txWord = {statusLatch, readValue};
        next_spiState = S_IDLE;
      end
      default: begin
        next_spiState = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      spiState <= S_IDLE;
      statusLatch <= 8'h00;
      txWord <= '0;
    end else begin
      spiState <= next_spiState;
      statusLatch <= next_statusLatch;
      txWord <= next_txWord;
    end
  end

  // UART receiver with baud measurement
  hsrp_uart_state_t uState;
  hsrp_uart_state_t next_uState;
  logic [MEASURE_BITS-1:0] count;
  logic [MEASURE_BITS-1:0] next_count;
  logic edgeSeen;
  logic next_edgeSeen;
  logic [BIT_TIME_BITS-1:0] bitTime;
  logic [BIT_TIME_BITS-1:0] next_bitTime;
  logic [TIMER_BITS-1:0] timer;
  logic [TIMER_BITS-1:0] next_timer;
  logic [2:0] bitIdx;
  logic [2:0] next_bitIdx;
  logic [7:0] shiftByte;
  logic [7:0] next_shiftByte;
  logic [2:0] byteIdx;
  logic [2:0] next_byteIdx;
  logic [7:0] crc;
  logic [7:0] next_crc;
  logic [7:0] dgram [0:7];
  logic [7:0] next_dgram [0:7];
  logic uartWr;
  logic [BIT_TIME_BITS-1:0] measured;

  assign measured = count[MEASURE_BITS-1:SYNC_MEASURE_SHIFT];

  always_comb begin
    next_uState = uState;
    next_count = count;
    next_edgeSeen = edgeSeen;
    next_bitTime = bitTime;
    next_timer = (timer != '0) ? timer - 24'h000001 : timer;
    next_bitIdx = bitIdx;
    next_shiftByte = shiftByte;
    next_byteIdx = byteIdx;
    next_crc = crc;
    next_dgram = dgram;
    uartWr = 1'b0;
    case (uState)
      U_IDLE: begin
        next_count = '0;
        next_edgeSeen = 1'b0;
        if (lineFall && uartMode) begin
          next_uState = U_MEASURE;
        end
      end
      U_MEASURE: begin
        next_count = count + 20'h00001;
        if (&count) begin
          next_uState = U_IDLE;
        end else if (lineFall) begin
          if (!edgeSeen) begin
            next_edgeSeen = 1'b1;
          end else if (measured < BIT_TIME_BITS'(UART_MIN_BIT_CLOCKS)) begin
            next_uState = U_IDLE;
          end else begin
            next_bitTime = measured;
            next_timer = TIMER_BITS'(measured[BIT_TIME_BITS-1:1]);
            next_bitIdx = SYNC_TAIL_FIRST_BIT;
            next_shiftByte = {5'h00, SYNC_LEAD_BITS};
            next_byteIdx = 3'h0;
            next_crc = CRC_INIT;
            next_uState = U_BITS;
          end
        end
      end
      U_WAIT_START: begin
        if (timer == '0) begin
          next_uState = U_IDLE;
        end else if (lineFall) begin
          next_timer = TIMER_BITS'(bitTime[BIT_TIME_BITS-1:1]);
          next_uState = U_START;
        end
      end
      U_START: begin
        if (timer == '0) begin
          if (lineLevel) begin
            next_uState = U_IDLE;
          end else begin
            next_timer = TIMER_BITS'(bitTime);
            next_bitIdx = 3'h0;
            next_uState = U_BITS;
          end
        end
      end
      U_BITS: begin
        if (timer == '0) begin
          next_shiftByte[bitIdx] = lineLevel;
          next_timer = TIMER_BITS'(bitTime);
          next_bitIdx = bitIdx + 3'h1;
          if (bitIdx == 3'h7) begin
            next_uState = U_STOP;
          end
        end
      end
      U_STOP: begin
        if (timer == '0) begin
          next_uState = U_IDLE;
          if (lineLevel) begin
            next_dgram[byteIdx] = shiftByte;
            if (byteIdx == READ_CRC_BYTE && !dgram[ACCESS_BYTE][UART_WRITE_SELECT_BIT]) begin
              next_uState = U_IDLE;
            end else if (byteIdx == WRITE_CRC_BYTE) begin
              uartWr = (shiftByte == crc) && (dgram[NODE_BYTE] == activeNode);
            end else begin
              next_crc = crc8Byte(crc, shiftByte);
              next_byteIdx = byteIdx + 3'h1;
              next_timer = TIMER_BITS'(bitTime) * TIMER_BITS'(UART_TIMEOUT_BITS);
              next_uState = U_WAIT_START;
            end
          end
        end
      end
      default: begin
        next_uState = U_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      uState <= U_IDLE;
      count <= '0;
      edgeSeen <= 1'b0;
      bitTime <= '0;
      timer <= '0;
      bitIdx <= 3'h0;
      shiftByte <= 8'h00;
      byteIdx <= 3'h0;
      crc <= CRC_INIT;
      for (int i = 0; i < 8; i++) begin
        dgram[i] <= 8'h00;
      end
    end else begin
      uState <= next_uState;
      count <= next_count;
      edgeSeen <= next_edgeSeen;
      bitTime <= next_bitTime;
      timer <= next_timer;
      bitIdx <= next_bitIdx;
      shiftByte <= next_shiftByte;
      byteIdx <= next_byteIdx;
      crc <= next_crc;
      dgram <= next_dgram;
    end
  end

  // Register access from whichever port is active
  logic wrReq;
  logic [ADDR_BITS-1:0] wrAddr;
  logic [DATA_BITS-1:0] wrData;

  always_comb begin
    wrReq = spiWr | uartWr;
    wrAddr = rxWord[FRAME_BITS-2:DATA_BITS];
    wrData = rxWord[DATA_BITS-1:0];
    if (uartMode) begin
      wrAddr = dgram[ACCESS_BYTE][ADDR_BITS-1:0];
      wrData = {dgram[3], dgram[4], dgram[5], dgram[6]};
    end
  end

  always_comb begin
    next_resetFlag = resetFlag;
    next_driverError = driverError | driverFaultEvent;
    next_nodeAddressField = nodeAddressField;
    next_strapValue = strapValue;
    next_strapPending = 1'b0;
    next_regAddr = regAddr;
    next_regWriteData = regWriteData;
    next_regWriteStrobe = 1'b0;
    next_regReadStrobe = 1'b0;
    if (strapPending) begin
      next_strapValue = {csSync, sckSync, sdiSync};
    end
    if (wrReq) begin
      next_regAddr = wrAddr;
      next_regWriteData = wrData;
      if (wrAddr == ADDR_GLOBAL_STATE) begin
        if (wrData[GS_DRIVER_ERROR]) begin
          next_driverError = driverFaultEvent;
        end
        if (wrData[GS_RESET_FLAG]) begin
          next_resetFlag = 1'b0;
        end
      end else if (wrAddr == ADDR_NODE_SETUP) begin
        next_nodeAddressField = wrData[7:0];
      end else begin
        next_regWriteStrobe = 1'b1;
      end
    end else if (spiRd) begin
      next_regAddr = rxWord[FRAME_BITS-2:DATA_BITS];
      next_regReadStrobe = !isLocal(rxWord[FRAME_BITS-2:DATA_BITS]);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      resetFlag <= 1'b1;
      driverError <= 1'b0;
      nodeAddressField <= NODE_ADDRESS_RESET;
      strapValue <= 3'h0;
      strapPending <= 1'b1;
      regAddr <= '0;
      regWriteData <= '0;
      regWriteStrobe <= 1'b0;
      regReadStrobe <= 1'b0;
      csPrev <= 1'b1;
      linePrev <= 1'b1;
      clockSourceInternal <= 1'b0;
      singleWireDataPinOut <= 1'b1;
      singleWireDataPinOutEn <= 1'b0;
    end else begin
      resetFlag <= next_resetFlag;
      driverError <= next_driverError;
      nodeAddressField <= next_nodeAddressField;
      strapValue <= next_strapValue;
      strapPending <= next_strapPending;
      regAddr <= next_regAddr;
      regWriteData <= next_regWriteData;
      regWriteStrobe <= next_regWriteStrobe;
      regReadStrobe <= next_regReadStrobe;
      csPrev <= csSync;
      linePrev <= lineLevel;
      clockSourceInternal <= lowPower;
      singleWireDataPinOut <= 1'b1;
      singleWireDataPinOutEn <= 1'b0;
    end
  end
endmodule

/* pkg/hsrp_pkg.sv */
// Purpose: Shared constants and types for the host serial register port
// Assumes: 100 MHz system clock, SPI clock arrives as its own clock port
// Notes: Offsets, field positions, reset values and counts live here
//
// How it works
// - Each SPI frame returns a status byte in bits 39:32; bits 7,5,3 zero.
// - Status bit 6 is set while any stop source halts motion.
// - Status bit 4 mirrors the target position reached flag.
// - Status bit 2 mirrors the target velocity reached flag.
// - Status bit 1 is the driver fault flag, cleared by writing one.
// - Status bit 0 is the reset flag, cleared by writing one.
// - Register data is right aligned in the 32-bit word.
// - Chip select stays low for the frame; clocks count only while low.
// - Input sampled on rising clock edge, output changes after falling edge.
// - Frames shift most significant bit first both ways.
// - Extra bits reappear on the output forty clocks later for chaining.
// - Chip select rising edge loads the last forty bits as the command.
// - UART datagram: sync byte, node, access byte, four data bytes, checksum.
// - Bit time is measured from start-bit fall to the sync bit 3 fall.
// - Each UART byte has a low start bit and a high stop bit.
// - UART data word goes high byte first, each byte LSB first.
// - Low power switches to internal oscillator, lowering the maximum baud.
// - An eight-bit node address field sits in the node setup register.
// - After reset the strap value is sampled from the shared SPI pins.
// - Top bit of the SPI address byte selects write when one.
// - SPI reply carries the previous read data or echoes the last write.
// - Active node address is the field plus the strap value.
// - UART checksum is CRC-8, poly x^8+x^2+x+1, init zero, LSB first.
package hsrp_pkg;
  localparam int FRAME_BITS = 40;
  localparam int DATA_BITS = 32;
  localparam int ADDR_BITS = 7;
  localparam int WRITE_SELECT_BIT = 39;
  localparam int UART_WRITE_SELECT_BIT = 7;

  localparam logic [6:0] ADDR_GLOBAL_STATE = 7'h01;
  localparam logic [6:0] ADDR_NODE_SETUP = 7'h03;
  localparam logic [7:0] NODE_ADDRESS_RESET = 8'h00;

  localparam int ST_STOP = 6;
  localparam int ST_POSITION = 4;
  localparam int ST_VELOCITY = 2;
  localparam int ST_DRIVER_ERROR = 1;
  localparam int ST_RESET_FLAG = 0;
  localparam int GS_DRIVER_ERROR = 1;
  localparam int GS_RESET_FLAG = 0;

  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [2:0] SYNC_LEAD_BITS = 3'h5;
  localparam logic [2:0] SYNC_TAIL_FIRST_BIT = 3'h3;
  localparam int SYNC_MEASURE_SHIFT = 2;
  localparam logic [2:0] NODE_BYTE = 3'h1;
  localparam logic [2:0] ACCESS_BYTE = 3'h2;
  localparam logic [2:0] READ_CRC_BYTE = 3'h3;
  localparam logic [2:0] WRITE_CRC_BYTE = 3'h7;
  localparam logic [5:0] UART_TIMEOUT_BITS = 6'h3f;
  localparam int CLK_PERIOD_NS = 10;
  localparam int UART_MIN_BAUD = 9000;
  localparam int UART_MIN_BIT_CLOCKS = 16;
  localparam int MEASURE_BITS = 20;
  localparam int BIT_TIME_BITS = MEASURE_BITS - SYNC_MEASURE_SHIFT;
  localparam int TIMER_BITS = 24;

  typedef enum {S_IDLE, S_READ_WAIT} hsrp_spi_state_t;
  typedef enum {U_IDLE, U_MEASURE, U_START, U_BITS, U_STOP, U_WAIT_START} hsrp_uart_state_t;
endpackage

/* hdl/hsrp_sync.sv */
// Purpose: Two-flop synchroniser for pin levels
// Assumes: Inputs are quasi-static levels
// Notes: No reset; reset must be held long enough to flush it
`timescale 1ns/100ps
module hsrp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk) begin
    meta <= d;
    q <= meta;
  end
endmodule

/* hdl/hsrp_spi_link.sv */
// Purpose: SPI shift register running on the host serial clock
// Assumes: Mode 3, clock idle high, txWord stable while chip select low
// Notes: Chip select high clears the frame state without a clock edge
`timescale 1ns/100ps
module hsrp_spi_link
  import hsrp_pkg::*;
(
  input wire logic spiClk,
  input wire logic spiCsN,
  input wire logic spiDataIn,
  input wire logic [hsrp_pkg::FRAME_BITS-1:0] txWord,
  output logic [hsrp_pkg::FRAME_BITS-1:0] rxWord,
  output logic spiDataOut,
  output logic spiDataOutEn
);
  import hsrp_pkg::*;

  logic started;
  logic [FRAME_BITS-1:0] shiftReg;
  logic [FRAME_BITS-1:0] next_shiftReg;

  // First rising edge of a frame seen
  always_ff @(posedge spiClk or posedge spiCsN) begin
    if (spiCsN) begin
      started <= 1'b0;
    end else begin
      started <= 1'b1;
    end
  end

  always_comb begin
    next_shiftReg = shiftReg;
    if (!spiCsN) begin
      // Reply loads on first edge, then bits pass through for chaining
      next_shiftReg = started ? {shiftReg[FRAME_BITS-2:0], spiDataIn}
                              : {txWord[FRAME_BITS-2:0], spiDataIn};
    end
  end

  always_ff @(posedge spiClk) begin
    shiftReg <= next_shiftReg;
  end

  // Output moves after each falling edge
  always_ff @(negedge spiClk or posedge spiCsN) begin
    if (spiCsN) begin
      spiDataOut <= 1'b0;
      spiDataOutEn <= 1'b0;
    end else begin
      spiDataOut <= started ? shiftReg[FRAME_BITS-1] : txWord[FRAME_BITS-1];
      spiDataOutEn <= 1'b1;
    end
  end

  // Stable whenever chip select is high
  assign rxWord = shiftReg;
endmodule

/* verification/hsrp_host_port_chk.sv */
// Purpose: Port checker for the host serial register port
// Assumes: Bound to hsrp_host_port
// Notes: Serial clock checks are reset by chip select
`timescale 1ns/100ps
module hsrp_host_port_chk
  import hsrp_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic lowPowerMode,
  input wire logic spiClk,
  input wire logic spiCsN,
  input wire logic spiDataOut,
  input wire logic spiDataOutEn,
  input wire logic singleWireDataPinOut,
  input wire logic singleWireDataPinOutEn,
  input wire logic [hsrp_pkg::ADDR_BITS-1:0] regAddr,
  input wire logic regWriteStrobe,
  input wire logic regReadStrobe,
  input wire logic clockSourceInternal
);
  import hsrp_pkg::*;

  a_out_released: assert property (
    @(posedge clk) disable iff (sys_rst) spiCsN |-> !spiDataOutEn && !spiDataOut)
    else $error("serial out driven while deselected");
  a_out_in_frame: assert property (
    @(posedge spiClk) disable iff (spiCsN) spiDataOutEn)
    else $error("serial out not enabled in frame");
  a_write_pulse: assert property (
    @(posedge clk) disable iff (sys_rst) regWriteStrobe |=> !regWriteStrobe)
    else $error("write strobe longer than one cycle");
  a_read_pulse: assert property (
    @(posedge clk) disable iff (sys_rst) regReadStrobe |=> !regReadStrobe && !regWriteStrobe)
    else $error("read strobe longer than one cycle");
  a_strobe_excl: assert property (
    @(posedge clk) disable iff (sys_rst) !(regWriteStrobe && regReadStrobe))
    else $error("read and write strobe together");
  a_after_select: assert property (
    @(posedge clk) disable iff (sys_rst)
    regWriteStrobe || regReadStrobe |-> spiCsN && $past(spiCsN, 2))
    else $error("access before chip select rose");
  a_internal_addr: assert property (
    @(posedge clk) disable iff (sys_rst)
    regWriteStrobe |-> regAddr != ADDR_GLOBAL_STATE && regAddr != ADDR_NODE_SETUP)
    else $error("internal register written outside");
  a_line_quiet: assert property (
    @(posedge clk) disable iff (sys_rst) singleWireDataPinOut && !singleWireDataPinOutEn)
    else $error("single wire pin driven");
  a_lowpower_on: assert property (
    @(posedge clk) disable iff (sys_rst) lowPowerMode [*5] |-> clockSourceInternal)
    else $error("internal clock source not reported");
  a_lowpower_off: assert property (
    @(posedge clk) disable iff (sys_rst) !lowPowerMode [*5] |-> !clockSourceInternal)
    else $error("internal clock source stuck");
endmodule

bind hsrp_host_port hsrp_host_port_chk chk (
  .clk, .sys_rst, .lowPowerMode, .spiClk, .spiCsN, .spiDataOut, .spiDataOutEn,
  .singleWireDataPinOut, .singleWireDataPinOutEn, .regAddr, .regWriteStrobe,
  .regReadStrobe, .clockSourceInternal
);

/* verification/hsrp_host_model.sv */
// Purpose: Host side model, SPI mode 3 and single-wire UART writer
// Assumes: Serial clock half period 15 ns, UART bit time 320 ns
// Notes: Idle pins hold address strap 7 at reset
`timescale 1ns/100ps
module hsrp_host_model (
  output logic spiClk,
  output logic spiCsN,
  output logic spiDataIn,
  input wire logic spiDataOut,
  output logic uartLine
);
  initial begin
    spiClk = 1'b1;
    spiCsN = 1'b1;
    spiDataIn = 1'b1;
    uartLine = 1'b1;
  end
  // Sends n bits of tx MSB first, reply shifted into rx
  task automatic frame(input logic [79:0] tx, input int n, output logic [79:0] rx);
    #3 spiCsN = 1'b0;
    rx = '0;
    #40;
    for (int i = n - 1; i >= 0; i--) begin
      spiClk = 1'b0;
      spiDataIn = tx[i];
      #15 spiClk = 1'b1;
      rx = {rx[78:0], spiDataOut};
      #15;
    end
    spiCsN = 1'b1;
    spiDataIn = ~spiDataIn;
    #100;
  endtask
  task automatic ubyte(input logic [7:0] b);
    uartLine = 1'b0;
    #320;
    for (int i = 0; i < 8; i++) begin
      uartLine = b[i];
      #320;
    end
    uartLine = 1'b1;
    #320;
  endtask
  // Read request datagram; no reply is awaited
  task automatic uread(input logic [7:0] node, input logic [7:0] acc);
    logic [23:0] g;
    logic [7:0] crc;
    g = {8'h05, node, acc};
    crc = 8'h00;
    for (int i = 0; i < 24; i++) begin
      crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ g[16 - 8 * (i / 8) + i % 8]) ? 8'h07 : 8'h00);
    end
    #3;
    for (int k = 0; k < 3; k++) begin
      ubyte(g[23 - 8 * k -: 8]);
    end
    ubyte(crc);
    #4000;
  endtask
  // Write datagram; flip corrupts the checksum
  task automatic uwrite(input logic [7:0] node, input logic [7:0] acc, input logic [31:0] d,
                        input logic [7:0] flip);
    logic [55:0] g;
    logic [7:0] crc;
    logic fb;
    g = {8'h05, node, acc, d};
    crc = 8'h00;
    for (int k = 0; k < 7; k++) begin
      for (int i = 0; i < 8; i++) begin
        fb = crc[7] ^ g[48 - 8 * k + i];
        crc = {crc[6:0], 1'b0} ^ (fb ? 8'h07 : 8'h00);
      end
    end
    #3;
    for (int k = 0; k < 7; k++) begin
      ubyte(g[55 - 8 * k -: 8]);
    end
    ubyte(crc ^ flip);
    #4000;
  endtask
endmodule

/* verification/test_host_serial_register_port.sv */
// Purpose: Self-checking bench for the host serial register port
// Assumes: Strap pins idle high, so node address starts at 7
// Notes: External registers answer with a pattern built from the address
`timescale 1ns/100ps
module test_host_serial_register_port;
  import hsrp_pkg::*;
  logic clk, sys_rst, uartModeSelect, lowPowerMode, drvFault;
  logic spiClk, spiCsN, spiDataIn, spiDataOut, spiDataOutEn;
  logic uartLine, uartOut, uartOutEn, swLine;
  logic [6:0] st;
  logic [6:0] regAddr, lastAddr;
  logic [31:0] regWriteData, regReadData, lastData;
  logic regWriteStrobe, regReadStrobe, clockSourceInternal;
  logic [7:0] nWr, n0, nRd;
  logic [79:0] rx;
  int fails, nTests, cycles;
  assign swLine = uartLine & (uartOutEn ? uartOut : 1'b1);

  hsrp_host_model host (.spiClk(spiClk), .spiCsN(spiCsN), .spiDataIn(spiDataIn),
    .spiDataOut(spiDataOut), .uartLine(uartLine));
  hsrp_host_port dut (.clk(clk), .sys_rst(sys_rst), .uartModeSelect(uartModeSelect),
    .lowPowerMode(lowPowerMode), .spiClk(spiClk), .spiCsN(spiCsN), .spiDataIn(spiDataIn),
    .spiDataOut(spiDataOut), .spiDataOutEn(spiDataOutEn), .singleWireDataPinIn(swLine),
    .singleWireDataPinOut(uartOut), .singleWireDataPinOutEn(uartOutEn),
    .stopLeft(st[0]), .stopRight(st[1]), .loadStallHalt(st[2]), .virtualStopLeft(st[3]),
    .virtualStopRight(st[4]), .positionReached(st[5]), .velocityReached(st[6]),
    .driverFaultEvent(drvFault), .regAddr(regAddr), .regWriteData(regWriteData),
    .regWriteStrobe(regWriteStrobe), .regReadStrobe(regReadStrobe),
    .regReadData(regReadData), .clockSourceInternal(clockSourceInternal));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(negedge clk) regReadData <= {4{1'b1, regAddr}};
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (regReadStrobe) nRd <= nRd + 8'h01;
    if (regWriteStrobe) begin
      nWr <= nWr + 8'h01;
      lastAddr <= regAddr;
      lastData <= regWriteData;
    end
    if (cycles == 40000) begin
      fails = fails + 1;
      complete_run;
    end
  end

  task automatic check(input string what, input logic [79:0] exp, input logic [79:0] got);
    nTests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic sf(input logic [39:0] tx);
    host.frame({40'h0, tx}, 40, rx);
  endtask
  task automatic sx(input logic [39:0] tx, input logic [39:0] exp, input logic [39:0] m,
                    input string what);
    sf(tx);
    check(what, {40'h0, exp & m}, {40'h0, rx[39:0] & m});
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    {sys_rst, uartModeSelect, lowPowerMode, drvFault, st} = {4'h8, 7'h00};
    {fails, nTests, cycles, nWr, nRd, lastAddr, lastData} = '0;
    repeat (4) @(posedge clk);
    @(negedge clk) sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    sx(40'h01_00000000, 40'h0, '1, "first reply");
    sx(40'h01_00000000, {8'h01, 32'h1}, '1, "reset flag");
    sx(40'h81_00000001, {8'h01, 32'h1}, '1, "reset flag read");
    sx(40'h01_00000000, 40'h1, 40'hffffffff, "write echo");
    sx(40'h01_00000000, 40'h0, '1, "reset flag cleared");
    $display("test reset flag done");
    @(negedge clk) drvFault = 1'b1;
    @(negedge clk) drvFault = 1'b0;
    sf(40'h01_00000000);
    sx(40'h81_00000002, {8'h02, 32'h2}, '1, "fault flag");
    sf(40'h01_00000000);
    sx(40'h01_00000000, 40'h0, '1, "fault cleared");
    $display("test fault flag done");
    for (int i = 0; i < 7; i++) begin
      @(negedge clk) st = 7'h01 << i;
      sf(40'h10_00000000);
      sx(40'h10_00000000, {i < 5 ? 8'h40 : (i == 5 ? 8'h10 : 8'h04), 32'h90909090}, '1,
         "status");
    end
    @(negedge clk) st = 7'h00;
    sf(40'h10_00000000);
    check("read strobes", {72'h0, 8'h0f}, {72'h0, nRd});
    $display("test status bits done");
    sf(40'h90_12345678);
    check("write", {41'h0, 7'h10, 32'h12345678}, {41'h0, lastAddr, lastData});
    sx(40'h10_00000000, {8'h00, 32'h12345678}, '1, "echo");
    $display("test external write done");
    host.frame({40'h11_22334455, 40'h90_0a0b0c0d}, 80, rx);
    check("chain", {40'h00_90909090, 40'h11_22334455}, rx);
    check("last forty", {41'h0, 7'h10, 32'h0a0b0c0d}, {41'h0, lastAddr, lastData});
    $display("test daisy chain done");
    @(negedge clk) uartModeSelect = 1'b1;
    repeat (10) @(negedge clk);
    n0 = nWr;
    host.uwrite(8'h07, 8'h90, 32'ha5a50f0f, 8'h00);
    check("uart write", {n0 + 8'h01, 32'ha5a50f0f}, {nWr, lastData});
    host.uwrite(8'h07, 8'h90, 32'h1, 8'h01);
    check("bad checksum", {8'h0, n0 + 8'h01}, {8'h0, nWr});
    host.uwrite(8'h06, 8'h90, 32'h2, 8'h00);
    check("other node", {8'h0, n0 + 8'h01}, {8'h0, nWr});
    sf(40'h90_00000099);
    check("spi in uart mode", {8'h0, n0 + 8'h01}, {8'h0, nWr});
    host.uread(8'h07, 8'h10);
    check("uart read", {8'h0, n0 + 8'h01}, {8'h0, nWr});
    host.uwrite(8'h07, 8'h83, 32'h5, 8'h00);
    host.uwrite(8'h0c, 8'h90, 32'h77, 8'h00);
    check("new node", {n0 + 8'h02, 32'h77}, {nWr, lastData});
    $display("test uart done");
    @(negedge clk) lowPowerMode = 1'b1;
    repeat (6) @(negedge clk);
    check("clock source", 80'h1, {79'h0, clockSourceInternal});
    lowPowerMode = 1'b0;
    repeat (6) @(negedge clk);
    check("clock source off", 80'h0, {79'h0, clockSourceInternal});
    $display("test low power done");
    complete_run;
  end
endmodule
